// ### srwg_top.sv
// module: supervisor reset stretcher, watchdog and chip-select gating
`timescale 1ns/1ps
module srwg_top
   import srwg_pkg::*;
#(
   parameter longint unsigned RESET_CYCLES = RESET_CYC,
   parameter longint unsigned WD_CYCLES = WD_CYC,
   parameter longint unsigned CE_CYCLES = CE_GRACE_CYC
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic supply_low_in,
   input wire logic supply_below_backup_in,
   input wire logic powerfail_sense_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_kick_float_in,
   input wire logic manual_reset_n,
   input wire logic chip_select_n_in,
   input wire logic seal_request_in,
   output logic reset_n_out,
   output logic chip_select_n_out,
   output logic powerfail_flag_n,
   output logic supply_sel_backup_out,
   output logic backup_connected_out
);
   // ------------------------------------------------------------------
   // synchronised inputs
   // ------------------------------------------------------------------
   logic kick_s;
   logic kick_float_s;
   logic mr_n_s;
   logic cs_n_s;
   srwg_sync #(.RST_VAL(1'b0)) u_sync_kick (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .d_in(watchdog_kick_in), .q_out(kick_s));
   srwg_sync #(.RST_VAL(1'b1)) u_sync_flt (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .d_in(watchdog_kick_float_in), .q_out(kick_float_s));
   srwg_sync #(.RST_VAL(1'b1)) u_sync_mr (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .d_in(manual_reset_n), .q_out(mr_n_s));
   srwg_sync #(.RST_VAL(1'b1)) u_sync_cs (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .d_in(chip_select_n_in), .q_out(cs_n_s));

   localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RESET_CYCLES - 1);
   localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYCLES - 1);
   localparam logic [CNT_W-1:0] CE_LAST = CNT_W'(CE_CYCLES - 1);

   srwg_state_t state_r;
   srwg_state_t state_nxt;
   logic [CNT_W-1:0] rst_cnt_r;
   logic [CNT_W-1:0] wd_cnt_r;
   logic [CNT_W-1:0] ce_cnt_r;
   logic kick_prev_r;
   logic ce_grace_r;
   logic sealed_r;
   logic reset_n_r;
   logic cs_n_r;
   logic pf_n_r;
   logic sel_bat_r;

   // ------------------------------------------------------------------
   // reset sources and stretch decode
   // ------------------------------------------------------------------
   wire hold_src = supply_low_in | ~mr_n_s;
   wire kick_edge = kick_s ^ kick_prev_r;
   wire wd_clear = ~reset_n_r | kick_float_s | kick_edge;
   wire wd_expire = ~wd_clear & (wd_cnt_r == WD_LAST);
   wire stretch_done = (rst_cnt_r == RST_LAST);

   // next state: hold while a source is active, then stretch, then run
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SRWG_HOLD: begin
            if (!hold_src) begin
               state_nxt = SRWG_STRETCH;
            end
         end
         SRWG_STRETCH: begin
            if (hold_src) begin
               state_nxt = SRWG_HOLD;
            end else if (stretch_done) begin
               state_nxt = SRWG_RUN;
            end
         end
         SRWG_RUN: begin
            if (hold_src) begin
               state_nxt = SRWG_HOLD;
            end else if (wd_expire) begin
               state_nxt = SRWG_STRETCH;
            end
         end
         default: state_nxt = SRWG_HOLD;
      endcase
   end

   // ------------------------------------------------------------------
   // sequencer and reset timer
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_r <= SRWG_HOLD;
         rst_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         // timer cleared outside the stretch so it restarts on recovery
         if (state_r == SRWG_STRETCH && !hold_src) begin
            rst_cnt_r <= rst_cnt_r + 1'b1;
         end else begin
            rst_cnt_r <= '0;
         end
      end
   end

   // reset output registered; low in every state but run
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         reset_n_r <= 1'b0;
      end else begin
         reset_n_r <= (state_nxt == SRWG_RUN);
      end
   end

   // ------------------------------------------------------------------
   // watchdog timer
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         wd_cnt_r <= '0;
         kick_prev_r <= 1'b0;
      end else begin
         kick_prev_r <= kick_s;
         if (wd_clear || wd_expire) begin
            wd_cnt_r <= '0;
         end else begin
            wd_cnt_r <= wd_cnt_r + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // chip-select gating with grace window after reset assertion
   // ------------------------------------------------------------------
   wire reset_falling = reset_n_r & (state_nxt != SRWG_RUN);
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         ce_grace_r <= 1'b0;
         ce_cnt_r <= '0;
      end else if (reset_falling) begin
         ce_grace_r <= ~cs_n_s;
         ce_cnt_r <= '0;
      end else if (ce_grace_r) begin
         ce_cnt_r <= ce_cnt_r + 1'b1;
         if (cs_n_s || ce_cnt_r == CE_LAST) begin
            ce_grace_r <= 1'b0;
         end
      end
   end

   // backup mode always wins: no path to the RAM during switchover
   wire cs_pass = (state_nxt == SRWG_RUN) | (ce_grace_r | reset_falling);
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         cs_n_r <= 1'b1;
      end else begin
         cs_n_r <= supply_below_backup_in | ~cs_pass | cs_n_s;
      end
   end

   // ------------------------------------------------------------------
   // power-fail flag, supply select and freshness seal
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         pf_n_r <= 1'b1;
         sel_bat_r <= 1'b0;
         sealed_r <= 1'b0;
      end else begin
         pf_n_r <= ~(~powerfail_sense_in | supply_below_backup_in);
         sel_bat_r <= supply_below_backup_in;
         // seal armed by a request present as the supply drops, while reset is still high
         if (seal_request_in && reset_n_r && supply_low_in) begin
            sealed_r <= 1'b1;
         end else if (!supply_low_in) begin
            sealed_r <= 1'b0;
         end
      end
   end

   assign reset_n_out = reset_n_r;
   assign chip_select_n_out = cs_n_r;
   assign powerfail_flag_n = pf_n_r;
   assign supply_sel_backup_out = sel_bat_r;
   assign backup_connected_out = sel_bat_r & ~sealed_r;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   AST_LOW_WHILE_SUPPLY: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) supply_low_in |=> !reset_n_out)
      else $error("reset released while supply low");
   AST_MR_HOLDS: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) !mr_n_s |=> !reset_n_out)
      else $error("reset released while manual reset low");
   AST_STRETCH_MIN: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      $rose(reset_n_out) |-> state_r == SRWG_RUN && $past(stretch_done))
      else $error("reset released before stretch done");
   AST_TIMER_CLEAR: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) supply_low_in |=> rst_cnt_r == '0)
      else $error("reset timer not cleared");
   AST_WD_EXPIRE: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) wd_expire |=> !reset_n_out)
      else $error("watchdog expiry did not reset");
   AST_WD_CLEAR: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) wd_clear |=> wd_cnt_r == '0)
      else $error("watchdog not cleared");
   AST_WD_FLOAT: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) kick_float_s |-> !wd_expire)
      else $error("floating kick expired watchdog");
   AST_CS_GATE: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      !chip_select_n_out |-> $past(!cs_n_s) && $past(cs_pass))
      else $error("chip select passed while gated");
   AST_CS_BACKUP: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) supply_below_backup_in |=> chip_select_n_out)
      else $error("chip select passed in backup");
   AST_PF_FLAG: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      (!powerfail_sense_in || supply_below_backup_in) |=> !powerfail_flag_n)
      else $error("power fail flag not low");
   AST_CE_GRACE: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) ce_grace_r |-> ce_cnt_r <= CE_LAST)
      else $error("grace window too long");

   // ------------------------------------------------------------------
   // sequencer, timer and gating detail
   // ------------------------------------------------------------------
   // hold state must never let reset go high, whatever the timer does
   AST_RST_LOW_HOLD: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) state_r == SRWG_HOLD |-> !reset_n_out)
      else $error("reset high in hold state");
   AST_TIMER_HOLD: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) state_r != SRWG_STRETCH |=> rst_cnt_r == '0)
      else $error("reset timer ran outside stretch");
   AST_EXPIRE_STRETCH: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      wd_expire && !hold_src |=> state_r == SRWG_STRETCH)
      else $error("expiry did not start stretch");
   // watchdog stays cleared for the whole time reset is low
   AST_WD_IDLE_RESET: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) !reset_n_out |=> wd_cnt_r == '0)
      else $error("watchdog counted during reset");
   AST_WD_KICK_EDGE: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) kick_edge |=> wd_cnt_r == '0)
      else $error("kick edge did not clear watchdog");
   // a rising chip-select ends the grace window for good
   AST_CE_EARLY_END: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      ce_grace_r && cs_n_s && !reset_falling |=> !ce_grace_r)
      else $error("grace kept after chip select rose");
   AST_CS_BLOCKED: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      state_nxt != SRWG_RUN && !ce_grace_r && !reset_falling
      |=> chip_select_n_out)
      else $error("chip select passed during reset");
   AST_PF_HIGH: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in)
      powerfail_sense_in && !supply_below_backup_in |=> powerfail_flag_n)
      else $error("power fail flag low without cause");
   // supply select is a plain one-cycle follower of the comparator
   AST_SEL_BACKUP: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) supply_below_backup_in |=> supply_sel_backup_out)
      else $error("backup not selected");
   AST_SEL_MAIN: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) !supply_below_backup_in |=> !supply_sel_backup_out)
      else $error("main supply not selected");
   // seal survives the whole low-supply period, opens on recovery
   AST_SEAL_KEEP: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) sealed_r && supply_low_in |=> sealed_r)
      else $error("seal dropped while supply low");
   AST_SEAL_OPEN: assert property (@(posedge sys_clk_in)
      disable iff (sys_rst_in) !supply_low_in |=> !sealed_r)
      else $error("seal kept after supply recovery");

   CV_WD_RESET: cover property (@(posedge sys_clk_in) wd_expire);
   CV_MANUAL: cover property (@(posedge sys_clk_in) $fell(mr_n_s));
   CV_SEAL: cover property (@(posedge sys_clk_in) $rose(sealed_r));
   CV_RELEASE: cover property (@(posedge sys_clk_in) $rose(reset_n_out));
   CV_GRACE: cover property (@(posedge sys_clk_in) $fell(ce_grace_r));
endmodule : srwg_top

// ### srwg_pkg.sv
// package: timing constants and states for the supervisor reset/watchdog block
package srwg_pkg;
   // ------------------------------------------------------------------
   // clock and documented times
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned RESET_TIME_MS = 200;
   localparam int unsigned CE_GRACE_US = 15;
   localparam int unsigned WD_TIMEOUT_MS = 1600;
   // ------------------------------------------------------------------
   // derived cycle counts (least times rounded up)
   // ------------------------------------------------------------------
   localparam longint unsigned RESET_CYC =
      (longint'(RESET_TIME_MS) * CLK_HZ + 999) / 1000;
   localparam longint unsigned CE_GRACE_CYC =
      (longint'(CE_GRACE_US) * CLK_HZ + 999_999) / 1_000_000;
   localparam longint unsigned WD_CYC =
      (longint'(WD_TIMEOUT_MS) * CLK_HZ + 999) / 1000;
   localparam int unsigned CNT_W = 32;
   // ------------------------------------------------------------------
   // reset sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRWG_HOLD = 2'b00,
      SRWG_STRETCH = 2'b01,
      SRWG_RUN = 2'b10
   } srwg_state_t;
endpackage : srwg_pkg

// ### srwg_sync.sv
// module: two-flop synchroniser for one input level
`timescale 1ns/1ps
module srwg_sync
   import srwg_pkg::*;
#(
   parameter logic RST_VAL = 1'b1
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_r;
   logic q_r;
   // ------------------------------------------------------------------
   // first stage read only by the second
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         meta_r <= RST_VAL;
         q_r <= RST_VAL;
      end else begin
         meta_r <= d_in;
         q_r <= meta_r;
      end
   end
   assign q_out = q_r;
endmodule : srwg_sync

// ### srwg_host_model.sv
// file: processor and ram model driving kick and chip select
`timescale 1ns/1ps
module srwg_host_model (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic kick_en_in,
   input wire logic float_en_in,
   input wire logic cs_req_in,
   output logic kick_out,
   output logic kick_float_out,
   output logic cs_n_out
);
   logic [2:0] div_r;
   logic float_seen_r;
   // ------------------------------------------------------------------
   // kick toggling while the processor runs out of reset, and once when the line floats
   // ------------------------------------------------------------------
   initial begin
      div_r = 3'h0;
      float_seen_r = 1'b0;
      kick_out = 1'b0;
   end
   // a floated line shows the inverse of the last level, then holds while kick_en_in is low
   always @(posedge sys_clk_in) begin
      div_r <= div_r + 3'h1;
      float_seen_r <= float_en_in;
      if (float_en_in && !float_seen_r) begin
         kick_out <= ~kick_out;
      end else if (kick_en_in && reset_n_in && div_r == 3'h7) begin
         kick_out <= ~kick_out;
      end
   end
   assign kick_float_out = float_en_in;
   // write cycle held low by the processor while requested
   assign cs_n_out = ~cs_req_in;
endmodule : srwg_host_model

// ### srwg_top_tb_top.sv
// file: self-checking bench for the supervisor reset block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   error_cnt++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module srwg_top_tb_top;
   import srwg_pkg::*;
   localparam int RC = 20;
   localparam int WD = 50;
   localparam int CE = 12;
   logic sys_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic sup_low = 1'b0, sup_bak = 1'b0, pf_sense = 1'b1, mr_n = 1'b1;
   logic seal = 1'b0, kick_en = 1'b0, float_en = 1'b0, cs_req = 1'b0;
   logic kick, kick_fl, cs_n, rst_n, cs_out_n, pf_n, sel_bak, bak_con;
   int error_cnt = 0, samples_checked = 0, cyc = 0, n;
   // ------------------------------------------------------------------
   // clock, timeout and instances
   // ------------------------------------------------------------------
   always #12.5 sys_clk_in = ~sys_clk_in;
   // ceiling well above the under a thousand cycles the tests need
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         summarize();
      end
   end
   srwg_host_model host_u (.sys_clk_in(sys_clk_in), .reset_n_in(rst_n),
      .kick_en_in(kick_en), .float_en_in(float_en), .cs_req_in(cs_req),
      .kick_out(kick), .kick_float_out(kick_fl), .cs_n_out(cs_n));
   srwg_top #(.RESET_CYCLES(RC), .WD_CYCLES(WD), .CE_CYCLES(CE)) dut_u (
      .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .supply_low_in(sup_low), .supply_below_backup_in(sup_bak),
      .powerfail_sense_in(pf_sense), .watchdog_kick_in(kick),
      .watchdog_kick_float_in(kick_fl), .manual_reset_n(mr_n),
      .chip_select_n_in(cs_n), .seal_request_in(seal),
      .reset_n_out(rst_n), .chip_select_n_out(cs_out_n),
      .powerfail_flag_n(pf_n), .supply_sel_backup_out(sel_bak),
      .backup_connected_out(bak_con));
   // ------------------------------------------------------------------
   // helpers and scenarios
   // ------------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk_in);
      #1;
   endtask : tick
   // release must come a full stretch after the last source drops
   task automatic wait_up(input string nm);
      n = 0;
      while (rst_n !== 1'b1 && n < 500) begin
         tick(1);
         n++;
      end
      `CHK(nm, 1'b1, n >= RC && n <= RC + 4)
      $display("test %s done", nm);
   endtask : wait_up
   task automatic t_hold(input string nm, input bit use_mr);
      if (use_mr) mr_n = 1'b0;
      else sup_low = 1'b1;
      tick(4);
      `CHK(nm, 1'b0, rst_n)
      tick(RC * 2);
      `CHK(nm, 1'b0, rst_n)
      mr_n = 1'b1;
      sup_low = 1'b0;
      wait_up(nm);
   endtask : t_hold
   task automatic t_wdog();
      kick_en = 1'b1;
      tick(WD * 3);
      `CHK("kicked", 1'b1, rst_n)
      kick_en = 1'b0;
      n = 0;
      while (rst_n === 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      `CHK("expiry", 1'b1, n >= WD - 8 && n <= WD + 6)
      wait_up("wdog");
      float_en = 1'b1;
      tick(WD * 3);
      `CHK("float", 1'b1, rst_n)
      float_en = 1'b0;
      kick_en = 1'b1;
   endtask : t_wdog
   task automatic t_cs();
      cs_req = 1'b1;
      tick(4);
      `CHK("cs pass", 1'b0, cs_out_n)
      sup_low = 1'b1;
      tick(1);
      n = 0;
      while (cs_out_n === 1'b0 && n < 100) begin
         tick(1);
         n++;
      end
      `CHK("grace", 1'b1, n >= CE - 1 && n <= CE + 3)
      sup_low = 1'b0;
      // one edge only, so the stretch count below starts from zero
      tick(1);
      `CHK("cs blocked", 1'b1, cs_out_n)
      wait_up("cs");
      sup_low = 1'b1;
      tick(1);
      cs_req = 1'b0;
      tick(3);
      // a fresh request after the window ended early must stay blocked
      cs_req = 1'b1;
      tick(5);
      `CHK("early end", 1'b1, cs_out_n)
      sup_low = 1'b0;
      wait_up("cs early");
   endtask : t_cs
   task automatic t_power();
      cs_req = 1'b1;
      pf_sense = 1'b0;
      tick(3);
      `CHK("pf sense", 1'b0, pf_n)
      pf_sense = 1'b1;
      tick(3);
      `CHK("pf high", 1'b1, pf_n)
      `CHK("main sel", 1'b0, sel_bak)
      sup_low = 1'b1;
      sup_bak = 1'b1;
      // looked at inside the grace window, where only backup blocks it
      tick(2);
      `CHK("cs bak", 1'b1, cs_out_n)
      tick(CE + 4);
      `CHK("pf bak", 1'b0, pf_n)
      `CHK("bak sel", 1'b1, sel_bak)
      `CHK("bak con", 1'b1, bak_con)
      sup_bak = 1'b0;
      sup_low = 1'b0;
      cs_req = 1'b0;
      wait_up("power");
   endtask : t_power
   task automatic t_seal();
      seal = 1'b1;
      sup_low = 1'b1;
      tick(3);
      sup_bak = 1'b1;
      tick(3);
      `CHK("sealed", 1'b0, bak_con)
      sup_bak = 1'b0;
      seal = 1'b0;
      sup_low = 1'b0;
      wait_up("seal");
   endtask : t_seal
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      tick(5);
      sys_rst_in = 1'b0;
      `CHK("por", 1'b1, cs_out_n)
      wait_up("por");
      t_hold("supply", 1'b0);
      t_hold("manual", 1'b1);
      t_wdog();
      t_cs();
      t_power();
      t_seal();
      summarize();
   end
endmodule : srwg_top_tb_top
